// [lmc_fifo.sv]
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Ready and valid come from registered full/empty state
`timescale 1ns/100ps
module lmc_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  lmc_strm_if.snk   wr,
  lmc_strm_if.src   rd
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Handshakes
  // ==========================================================================
  assign wr.ready = (count_q != (AW+1)'(DEPTH));
  assign rd.valid = (count_q != '0);
  assign rd.data  = mem_q[rd_ptr_q];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // Storage, one entry per generate step
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem_q[i] <= '0;
      end else if (push && (wr_ptr_q == AW'(i))) begin
        mem_q[i] <= wr.data;
      end
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end

endmodule : lmc_fifo

// [lmc_host_bus.sv]
// Purpose: Host serial port and bus line beside the controller
// Assumes: Bus has a pull-up; other nodes may pull it low
// Notes:   Regulator counts as stable three cycles after enable
`timescale 1ns/100ps
module lmc_host_bus (
  input  wire logic clk,
  input  wire logic host_txd,
  input  wire logic node_dom,
  input  wire logic lin_out,
  input  wire logic lin_oe,
  input  wire logic reg_en,
  output logic      txd_pin,
  output logic      lin_in,
  output logic      reg_stable
);
  logic [2:0] stab_q = 3'h0;
  // =========
  // Bus wire
  // =========
  // open-drain wire
  // Any dominant driver beats the pull-up
  assign lin_in = (lin_oe ? lin_out : 1'b1) & !node_dom;
  // host releases transmit
  // Unpowered pull-up reads low, so an idle host never feeds the device
  assign txd_pin = reg_en ? host_txd : 1'b0;
  // Regulator settles slowly but drops at once
  always_ff @(posedge clk) begin
    stab_q <= reg_en ? {stab_q[1:0], 1'b1} : 3'h0;
  end
  assign reg_stable = stab_q[2] & reg_en;
endmodule : lmc_host_bus

// [lmc_mode_ctrl.sv]
// Purpose: Mode and protection control of a single-wire bus transceiver
// Assumes: sys_rst stands for battery power-on; all pins are asynchronous
// Notes:   The bus pin is open drain: lin_out is low, lin_oe drives it
//
// Functional notes
// - Power-down: transmitter and regulator both off
// - Bus activity in power-down wakes regulator
// - Power-down goes to operation on wake high
// - Ready states: regulator on, bus recessive
// - Ready: wake rising edge enters operation
// - Quiet ready: wake falling edge enters ready
// - Power-down reached only from operation
// - Power-on starts in a ready state
// - Wake input ignored 600 us after settling; here only after the first settle following power-on
// - Wake input is edge sensitive
// - Operation: wake falling edge enters power-down
// - Thermal overload shuts transmitter; regulator shut only on regulator overload
// - After overload, quiet ready needs toggle
// - Overload: transmitter off, receive reads high
// - Low receive with high transmit: contention
// - Transmit low drives bus dominant
// - Receive output follows sensed bus
`timescale 1ns/100ps
module lmc_mode_ctrl
  import lmc_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES  = BLANK_CYC,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned HOLD_CYCLES   = HOLD_CYC,
  parameter int unsigned DEPTH         = FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       txd_pin,
  input  wire logic       wake_pin,
  input  wire logic       lin_in,
  input  wire logic       reg_stable,
  input  wire logic       thermal_ovl,
  input  wire logic       reg_ovl,
  output logic            rxd,
  output logic            lin_out,
  output logic            lin_oe,
  output logic            reg_en,
  output logic            tx_en,
  output logic [2:0]      mode,
  output logic            overload,
  output logic            contention,
  output logic            wake_armed,
  output logic            txd_stall
);

  localparam int unsigned BW = $clog2(BLANK_CYCLES + 1);
  localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);
  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned PW = $clog2(POR_CYC + 1);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [IN_NUM-1:0] in_raw;
  logic [IN_NUM-1:0] sync1_q;
  logic [IN_NUM-1:0] sync2_q;
  logic [IN_NUM-1:0] sync3_q;
  logic [IN_NUM-1:0] flt_q;

  logic              f_txd;
  logic              f_wake;
  logic              f_lin;
  logic              f_reg_ok;
  logic              f_therm;
  logic              f_reg_ovl;

  lmc_mode_e         mode_q;
  logic [PW-1:0]     por_cnt_q;
  logic [SW-1:0]     settle_cnt_q;
  logic              settled;
  logic [BW-1:0]     blank_cnt_q;
  logic              blank_done_q;
  logic              wake_prev_q;
  logic              wake_rise;
  logic              wake_fall;
  logic              lin_prev_q;
  logic              lin_fall;

  logic              txd_last_q;
  logic              tx_lvl_q;
  logic [HW-1:0]     hold_cnt_q;

  logic              rxd_q;
  logic              lin_oe_q;
  logic              lin_out_q;
  logic              reg_en_q;
  logic              tx_en_q;
  logic [2:0]        mode_out_q;
  logic              overload_q;
  logic              contention_q;
  logic              txd_stall_q;

  lmc_strm_if #(.W(FIFO_WIDTH)) push_if ();
  lmc_strm_if #(.W(FIFO_WIDTH)) pop_if ();

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  assign in_raw[IN_TXD]     = txd_pin;
  assign in_raw[IN_WAKE]    = wake_pin;
  assign in_raw[IN_LIN]     = lin_in;
  assign in_raw[IN_REG_OK]  = reg_stable;
  assign in_raw[IN_THERM]   = thermal_ovl;
  assign in_raw[IN_REG_OVL] = reg_ovl;

  // Three stages per pin; a new level counts once stages two and three
  // agree, which also rejects a single-cycle glitch
  for (genvar i = 0; i < IN_NUM; i++) begin : g_sync
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync1_q[i] <= IN_RST[i];
        sync2_q[i] <= IN_RST[i];
        sync3_q[i] <= IN_RST[i];
        flt_q[i]   <= IN_RST[i];
      end else begin
        sync1_q[i] <= in_raw[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        if (sync2_q[i] == sync3_q[i]) flt_q[i] <= sync3_q[i];
      end
    end
  end

  assign f_txd     = flt_q[IN_TXD];
  assign f_wake    = flt_q[IN_WAKE];
  assign f_lin     = flt_q[IN_LIN];
  assign f_reg_ok  = flt_q[IN_REG_OK];
  assign f_therm   = flt_q[IN_THERM];
  assign f_reg_ovl = flt_q[IN_REG_OVL];

  // ==========================================================================
  // Regulator settle and wake blanking
  // ==========================================================================
  // Settle counter runs only while the regulator is on and reports good
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_cnt_q <= '0;
    end else if (!reg_en_q || !f_reg_ok) begin
      settle_cnt_q <= '0;
    end else if (!settled) begin
      settle_cnt_q <= settle_cnt_q + 1'b1;
    end
  end

  assign settled = (settle_cnt_q == SW'(SETTLE_CYCLES));

  // blanking after settle
  // Counted once after power-on; later regulator restarts do not re-blank,
  // so a wake from power-down is seen at once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blank_cnt_q  <= '0;
      blank_done_q <= 1'b0;
    end else if (!blank_done_q && settled) begin
      if (blank_cnt_q == BW'(BLANK_CYCLES - 1)) begin
        blank_done_q <= 1'b1;
      end
      blank_cnt_q <= blank_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // Edge detection
  // ==========================================================================
  // gated edge detect
  // The previous level tracks even while blanked, so an input already high
  // at the end of blanking gives no edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_prev_q <= IN_RST[IN_WAKE];
      lin_prev_q  <= IN_RST[IN_LIN];
    end else begin
      wake_prev_q <= f_wake;
      lin_prev_q  <= f_lin;
    end
  end

  assign wake_rise = blank_done_q & f_wake & ~wake_prev_q;
  assign wake_fall = blank_done_q & ~f_wake & wake_prev_q;
  // Falling bus edge, such as the start of a break, is bus activity
  assign lin_fall  = ~f_lin & lin_prev_q;

  // ==========================================================================
  // Power-on delay
  // ==========================================================================
  // Holds the power-on state until the wake level has been filtered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_cnt_q <= '0;
    end else if (mode_q == MODE_POR && por_cnt_q != PW'(POR_CYC)) begin
      por_cnt_q <= por_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // Mode register
  // ==========================================================================
  // mode state register
  // Overload takes priority over every wake event outside power-on and power-down, where it is not checked
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= MODE_POR;
    end else begin
      case (mode_q)
        MODE_POR: begin
          if (por_cnt_q == PW'(POR_CYC)) begin
            mode_q <= f_wake ? MODE_QREADY : MODE_READY;
          end
        end
        MODE_READY: begin
          if (f_therm) begin
            mode_q <= MODE_OVERLOAD;
          end else if (wake_rise) begin
            mode_q <= MODE_OPER;
          end
        end
        MODE_QREADY: begin
          if (f_therm) begin
            mode_q <= MODE_OVERLOAD;
          end else if (wake_fall) begin
            mode_q <= MODE_READY;
          end
        end
        MODE_OPER: begin
          if (f_therm) begin
            mode_q <= MODE_OVERLOAD;
          end else if (wake_fall) begin
            mode_q <= MODE_PDOWN;
          end
        end
        MODE_PDOWN: begin
          if (wake_rise) begin
            mode_q <= MODE_OPER;
          end else if (lin_fall) begin
            mode_q <= MODE_WAKING;
          end
        end
        MODE_WAKING: begin
          if (f_therm) begin
            mode_q <= MODE_OVERLOAD;
          end else if (settled) begin
            mode_q <= MODE_READY;
          end
        end
        MODE_OVERLOAD: begin
          if (!f_therm) begin
            mode_q <= MODE_QREADY;
          end
        end
        default: begin
          mode_q <= MODE_POR;
        end
      endcase
    end
  end

  // ==========================================================================
  // Regulator and transmitter enables
  // ==========================================================================
  // power-down all off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_en_q <= 1'b0;
      tx_en_q  <= 1'b0;
    end else begin
      case (mode_q)
        MODE_READY, MODE_QREADY, MODE_OPER, MODE_WAKING: begin
          reg_en_q <= 1'b1;
        end
        MODE_OVERLOAD: begin
          reg_en_q <= ~f_reg_ovl;
        end
        default: begin
          reg_en_q <= 1'b0;
        end
      endcase
      tx_en_q <= (mode_q == MODE_OPER) && !f_therm;
    end
  end

  // ==========================================================================
  // Transmit path through the FIFO
  // ==========================================================================
  // Each change of the transmit input that is accepted is one word; when the FIFO is full the
  // newest level stays pending and is offered again, so a change undone while full is dropped
  assign push_if.valid = (f_txd != txd_last_q);
  assign push_if.data  = FIFO_WIDTH'(f_txd);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_last_q <= TX_LVL_RST;
    end else if (push_if.valid && push_if.ready) begin
      txd_last_q <= f_txd;
    end
  end

  // Drain side stalls while the current level is held, giving the slope
  // control its time; fast toggling therefore fills the FIFO
  assign pop_if.ready = (hold_cnt_q == '0);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_lvl_q   <= TX_LVL_RST;
      hold_cnt_q <= '0;
    end else if (pop_if.valid && pop_if.ready) begin
      tx_lvl_q   <= pop_if.data[0];
      hold_cnt_q <= HW'(HOLD_CYCLES - 1);
    end else if (hold_cnt_q != '0) begin
      hold_cnt_q <= hold_cnt_q - 1'b1;
    end
  end

  lmc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) lmc_fifo_i (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr      (push_if),
    .rd      (pop_if)
  );

  // ==========================================================================
  // Pin drivers and status
  // ==========================================================================
  // dominant on low
  // recessive unless operating
  // Open drain: the pin is pulled low only while enabled and dominant
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lin_oe_q  <= 1'b0;
      lin_out_q <= 1'b0;
    end else begin
      lin_oe_q  <= (mode_q == MODE_OPER) && !f_therm && !tx_lvl_q;
      lin_out_q <= 1'b0;
    end
  end

  // overload reads high
  // With the driver off the bus floats recessive, so the receive output
  // reads high while the host holds transmit low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_q <= RXD_RST;
    end else begin
      rxd_q <= f_lin;
    end
  end

  // contention flag
  // Only meaningful while the driver is released, so it reads the level
  // actually asked of the bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      contention_q <= 1'b0;
    end else begin
      contention_q <= (mode_q == MODE_OPER) && tx_lvl_q && f_txd && !f_lin;
    end
  end

  // Mode, overload and back-pressure status for observation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_out_q  <= MODE_POR;
      overload_q  <= 1'b0;
      txd_stall_q <= 1'b0;
    end else begin
      mode_out_q  <= mode_q;
      overload_q  <= (mode_q == MODE_OVERLOAD);
      txd_stall_q <= ~push_if.ready;
    end
  end

  assign rxd        = rxd_q;
  assign lin_out    = lin_out_q;
  assign lin_oe     = lin_oe_q;
  assign reg_en     = reg_en_q;
  assign tx_en      = tx_en_q;
  assign mode       = mode_out_q;
  assign overload   = overload_q;
  assign contention = contention_q;
  assign wake_armed = blank_done_q;
  assign txd_stall  = txd_stall_q;

endmodule : lmc_mode_ctrl

// [lmc_mode_ctrl_sva.sv]
// Purpose: Port checks for the transceiver mode controller
// Assumes: One clock, sys_rst active high
// Notes:   Mode output lags internal state by one cycle
`timescale 1ns/100ps
module lmc_mode_ctrl_sva
  import lmc_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       txd_pin,
  input wire logic       wake_pin,
  input wire logic       lin_in,
  input wire logic       reg_stable,
  input wire logic       thermal_ovl,
  input wire logic       reg_ovl,
  input wire logic       rxd,
  input wire logic       lin_out,
  input wire logic       lin_oe,
  input wire logic       reg_en,
  input wire logic       tx_en,
  input wire logic [2:0] mode,
  input wire logic       overload,
  input wire logic       contention,
  input wire logic       wake_armed,
  input wire logic       txd_stall
);
  // =========
  // Mode steps
  // =========
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence pdown_entry_s;
    $changed(mode) && mode == MODE_PDOWN;
  endsequence
  sequence oper_entry_s;
    $changed(mode) && mode == MODE_OPER;
  endsequence
  sequence ovl_leave_s;
    $changed(mode) && $past(mode) == MODE_OVERLOAD;
  endsequence
  pdown_reg_off_a: assert property ((mode == MODE_PDOWN)[*2] |-> !reg_en && !tx_en)
    else $error("regulator or transmitter on in power-down");
  ready_reg_on_a: assert property ((mode == MODE_READY || mode == MODE_QREADY)[*2]
    |-> reg_en && !tx_en) else $error("ready state with wrong enables");
  oe_needs_tx_a: assert property ((!tx_en)[*2] |-> !lin_oe && !lin_out)
    else $error("bus driven without transmitter");
  pdown_from_oper_a: assert property (pdown_entry_s |-> $past(mode) == MODE_OPER)
    else $error("power-down entered from wrong mode");
  oper_entry_a: assert property (oper_entry_s
    |-> $past(mode) inside {MODE_READY, MODE_PDOWN})
    else $error("operation entered from wrong mode");
  por_exit_a: assert property ($past(mode) == MODE_POR && mode != MODE_POR
    |-> mode inside {MODE_READY, MODE_QREADY}) else $error("power-on left to wrong mode");
  blank_gate_a: assert property (!wake_armed |-> !(mode inside {MODE_OPER, MODE_PDOWN}))
    else $error("wake edge taken before blanking ended");
  ovl_tx_off_a: assert property (overload[*3] |-> !tx_en && !lin_oe)
    else $error("transmitter active in overload");
  ovl_exit_a: assert property (ovl_leave_s |-> mode == MODE_QREADY)
    else $error("overload left to wrong mode");
  rxd_follow_a: assert property (($stable(lin_in))[*8] |-> rxd == lin_in)
    else $error("receive output differs from settled bus");
endmodule : lmc_mode_ctrl_sva

bind lmc_mode_ctrl lmc_mode_ctrl_sva lmc_mode_ctrl_sva_i (
  .clk(clk), .sys_rst(sys_rst), .txd_pin(txd_pin), .wake_pin(wake_pin), .lin_in(lin_in),
  .reg_stable(reg_stable), .thermal_ovl(thermal_ovl), .reg_ovl(reg_ovl), .rxd(rxd),
  .lin_out(lin_out), .lin_oe(lin_oe), .reg_en(reg_en), .tx_en(tx_en), .mode(mode),
  .overload(overload), .contention(contention), .wake_armed(wake_armed),
  .txd_stall(txd_stall));

// [lmc_pkg.sv]
// Purpose: Shared constants and types for the transceiver mode controller
// Assumes: 40 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them, except POR_CYC, which is given in cycles
package lmc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned CLK_PER_US     = CLK_HZ / 1_000_000;
  // Wake-input blanking after regulator settles (least time, round up)
  localparam int unsigned BLANK_TIME_US  = 600;
  localparam int unsigned BLANK_CYC      = BLANK_TIME_US * CLK_PER_US;
  // Regulator settle time before it counts as stable
  localparam int unsigned SETTLE_TIME_US = 10;
  localparam int unsigned SETTLE_CYC     = SETTLE_TIME_US * CLK_PER_US;
  // Least time the driver holds one bus level, a crude slope control
  localparam int unsigned HOLD_TIME_NS   = 1000;
  localparam int unsigned HOLD_CYC       = (HOLD_TIME_NS * CLK_PER_US + 999) / 1000;
  // Cycles spent in the power-on state so the synchronisers are filled
  localparam int unsigned POR_CYC        = 4;

  // ==========================================================================
  // Buffering
  // ==========================================================================
  localparam int unsigned FIFO_DEPTH     = 16;
  localparam int unsigned FIFO_WIDTH     = 1;

  // ==========================================================================
  // Input synchroniser bit positions and reset levels
  // ==========================================================================
  localparam int unsigned IN_TXD         = 0;
  localparam int unsigned IN_WAKE        = 1;
  localparam int unsigned IN_LIN         = 2;
  localparam int unsigned IN_REG_OK      = 3;
  localparam int unsigned IN_THERM       = 4;
  localparam int unsigned IN_REG_OVL     = 5;
  localparam int unsigned IN_NUM         = 6;
  // Idle levels: transmit input and bus recessive high, others low
  localparam logic [5:0]  IN_RST         = 6'h05;
  localparam logic        RXD_RST        = 1'b1;
  localparam logic        TX_LVL_RST     = 1'b1;

  // ==========================================================================
  // Modes
  // ==========================================================================
  typedef enum logic [2:0] {
    MODE_POR      = 3'h0,
    MODE_READY    = 3'h1,
    MODE_QREADY   = 3'h2,
    MODE_OPER     = 3'h3,
    MODE_PDOWN    = 3'h4,
    MODE_WAKING   = 3'h5,
    MODE_OVERLOAD = 3'h6
  } lmc_mode_e;

endpackage : lmc_pkg

// [lmc_strm_if.sv]
// Purpose: Valid/ready word stream between the controller and its FIFO
// Assumes: Single clock domain
// Notes:   A word moves when valid and ready are both high at a clock edge
`timescale 1ns/100ps
interface lmc_strm_if #(
  parameter int unsigned W = 1
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : lmc_strm_if

// [test_lmc_mode_ctrl.sv]
// Purpose: Self-checking bench for the mode controller
// Assumes: Short blanking, settle and hold counts
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
module test_lmc_mode_ctrl
  import lmc_pkg::*;
;
  logic       clk         = 1'b0;
  logic       sys_rst     = 1'b1;
  logic       host_txd    = 1'b1;
  logic       wake_pin    = 1'b0;
  logic       node_dom    = 1'b0;
  logic       thermal_ovl = 1'b0;
  logic       reg_ovl     = 1'b0;
  logic       txd_pin, lin_in, reg_stable, rxd, lin_out, lin_oe, reg_en, tx_en;
  logic       overload, contention, wake_armed, txd_stall;
  logic [2:0] mode;
  int         errors      = 0;
  int         checked     = 0;

  lmc_mode_ctrl #(.BLANK_CYCLES(20), .SETTLE_CYCLES(4), .HOLD_CYCLES(6), .DEPTH(16))
    lmc_mode_ctrl_i (
    .clk(clk), .sys_rst(sys_rst), .txd_pin(txd_pin), .wake_pin(wake_pin), .lin_in(lin_in),
    .reg_stable(reg_stable), .thermal_ovl(thermal_ovl), .reg_ovl(reg_ovl), .rxd(rxd),
    .lin_out(lin_out), .lin_oe(lin_oe), .reg_en(reg_en), .tx_en(tx_en), .mode(mode),
    .overload(overload), .contention(contention), .wake_armed(wake_armed),
    .txd_stall(txd_stall));
  lmc_host_bus lmc_host_bus_i (.clk(clk), .host_txd(host_txd), .node_dom(node_dom),
    .lin_out(lin_out), .lin_oe(lin_oe), .reg_en(reg_en), .txd_pin(txd_pin),
    .lin_in(lin_in), .reg_stable(reg_stable));

  // =========
  // Helpers
  // =========
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Bounded wait; the caller compares afterwards
  task automatic to_mode(input logic [2:0] m);
    for (int i = 0; i < 80 && mode !== m; i++) @(negedge clk);
  endtask : to_mode
  task automatic power_on(input logic w);
    sys_rst = 1'b1;
    wake_pin = w;
    cyc(2);
    sys_rst = 1'b0;
  endtask : power_on
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // =========
  // Scenarios
  // =========
  task automatic test_quiet_start();
    power_on(1'b1);
    to_mode(MODE_QREADY);
    chk(mode, MODE_QREADY);
    cyc(2);
    chk({reg_en, tx_en, lin_oe}, 3'b100);
    wake_pin = 1'b0;
    cyc(8);
    chk({mode[1:0], wake_armed}, 3'b100);
    // host waits for the blanking to end before toggling
    for (int i = 0; i < 200 && wake_armed !== 1'b1; i++) @(negedge clk);
    wake_pin = 1'b1;
    cyc(12);
    chk(mode, MODE_QREADY);
    wake_pin = 1'b0;
    to_mode(MODE_READY);
    chk(mode, MODE_READY);
    $display("quiet start test done");
  endtask : test_quiet_start
  task automatic test_ready_oper();
    wake_pin = 1'b1;
    to_mode(MODE_OPER);
    chk(mode, MODE_OPER);
    cyc(20);
    chk({reg_en, tx_en, lin_oe}, 3'b110);
    chk(mode, MODE_OPER);
    $display("ready to operation test done");
  endtask : test_ready_oper
  task automatic test_txd_path();
    host_txd = 1'b0;
    cyc(20);
    chk({lin_oe, lin_in, rxd}, 3'b100);
    host_txd = 1'b1;
    cyc(20);
    chk({lin_oe, lin_in, rxd}, 3'b011);
    node_dom = 1'b1;
    cyc(12);
    chk({contention, rxd, lin_oe}, 3'b100);
    node_dom = 1'b0;
    cyc(12);
    chk({contention, rxd, lin_oe}, 3'b010);
    $display("transmit path test done");
  endtask : test_txd_path
  task automatic test_fifo();
    // Changes arrive faster than the driver may pass them on
    for (int i = 0; i < 80 && txd_stall !== 1'b1; i++) begin
      host_txd = ~host_txd;
      cyc(3);
    end
    chk({2'h0, txd_stall}, 3'h1);
    host_txd = 1'b1;
    cyc(200);
    chk({txd_stall, lin_oe, rxd}, 3'b001);
    $display("transmit buffer test done");
  endtask : test_fifo
  task automatic test_power_down();
    wake_pin = 1'b0;
    to_mode(MODE_PDOWN);
    chk(mode, MODE_PDOWN);
    cyc(3);
    chk({reg_en, tx_en, lin_oe}, 3'b000);
    wake_pin = 1'b1;
    to_mode(MODE_OPER);
    chk(mode, MODE_OPER);
    wake_pin = 1'b0;
    to_mode(MODE_PDOWN);
    cyc(5);
    node_dom = 1'b1;
    cyc(6);
    node_dom = 1'b0;
    to_mode(MODE_READY);
    chk(mode, MODE_READY);
    chk({reg_en, tx_en, lin_oe}, 3'b100);
    $display("power-down test done");
  endtask : test_power_down
  task automatic test_overload();
    wake_pin = 1'b1;
    to_mode(MODE_OPER);
    host_txd = 1'b0;
    cyc(12);
    thermal_ovl = 1'b1;
    to_mode(MODE_OVERLOAD);
    chk(mode, MODE_OVERLOAD);
    cyc(12);
    chk({tx_en, lin_oe, rxd}, 3'b001);
    chk({overload, lin_out, rxd}, 3'b101);
    chk({2'h0, reg_en}, 3'h1);
    reg_ovl = 1'b1;
    cyc(6);
    chk({2'h0, reg_en}, 3'h0);
    thermal_ovl = 1'b0;
    reg_ovl = 1'b0;
    host_txd = 1'b1;
    to_mode(MODE_QREADY);
    chk(mode, MODE_QREADY);
    wake_pin = 1'b0;
    to_mode(MODE_READY);
    wake_pin = 1'b1;
    to_mode(MODE_OPER);
    chk(mode, MODE_OPER);
    $display("overload test done");
  endtask : test_overload
  task automatic test_ready_start();
    power_on(1'b0);
    to_mode(MODE_READY);
    chk(mode, MODE_READY);
    $display("ready start test done");
  endtask : test_ready_start

  initial begin
    test_quiet_start();
    test_ready_oper();
    test_txd_path();
    test_fifo();
    test_power_down();
    test_overload();
    test_ready_start();
    print_verdict();
  end
  // Whole run needs about 600 cycles; over thirty times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule : test_lmc_mode_ctrl
